// >>> pkg/scsi_req_cfg.svh
// Constants for the SCSI request queue engine
`ifndef SCSI_REQ_CFG_SVH
`define SCSI_REQ_CFG_SVH

`define HDR_FIXED_BYTES   32'h0000_0013
`define PI_HDR_BYTES      32'h0000_0008
`define STS_FIXED_BYTES   32'h0000_000C
`define SENSE_SIZE_RST    32'h0000_0060
`define CDB_SIZE_RST      32'h0000_0020
`define MAX_TARGET_RST    8'hFF
`define CTRL_RST          8'h00

`define FEAT_INOUT_BIT    0
`define FEAT_PI_BIT       3
`define CTRL_SIMPLE_BIT   4

`define REG_CTRL          8'h00
`define REG_SENSE_SIZE    8'h04
`define REG_CDB_SIZE      8'h08
`define REG_MAX_TARGET    8'h0C
`define REG_STATUS        8'h10
`define REG_DONE_COUNT    8'h14

`define LUN_WK0           8'hC1
`define LUN_WK1           8'h01
`define LUN_NORMAL0       8'h01
`define LUN_UNIT_MSK      8'h3F

`define ATTR_SIMPLE       8'h00
`define ATTR_ORDERED      8'h01
`define ATTR_HEAD         8'h02
`define ATTR_ACA          8'h03

`define RESP_OK           8'h00
`define RESP_OVERRUN      8'h01
`define RESP_ABORTED      8'h02
`define RESP_BAD_TARGET   8'h03
`define RESP_RESET        8'h04
`define RESP_BUSY         8'h05
`define RESP_TRANSPORT    8'h06
`define RESP_TARGET_FAIL  8'h07
`define RESP_NEXUS_FAIL   8'h08
`define RESP_FAILURE      8'h09

`endif

// >>> pkg/scsi_req_pkg.sv
// Types for the SCSI request queue engine
`default_nettype none
package scsi_req_pkg;

    typedef enum logic [1:0] {
        ATTR_SIMPLE_E, ATTR_ORDERED_E, ATTR_HEAD_E, ATTR_ACA_E
    } task_attr_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_DECODE, ST_EXEC, ST_WAIT, ST_RESP
    } eng_state_t;

    typedef struct packed {
        logic [7:0]       qid;
        logic [7:0][7:0]  lun;
        logic [63:0]      id;
        logic [7:0]       task_attr;
        logic [7:0]       prio;
        logic [7:0]       crn;
        logic [31:0]      rd_len;
        logic [31:0]      wr_len;
        logic [31:0]      prot_out_count;
        logic [31:0]      prot_in_count;
    } req_t;

    typedef struct packed {
        logic [7:0]  qid;
        logic [63:0] id;
        logic        report_luns;
        logic [7:0]  target;
        logic [13:0] unit;
        task_attr_t  attr;
        logic [7:0]  crn;
        logic [31:0] cdb_len;
        logic [31:0] dataout_off;
        logic [31:0] dataout_len;
        logic [31:0] prot_in_off;
        logic [31:0] datain_off;
        logic [31:0] datain_len;
    } exec_t;

    typedef struct packed {
        logic [7:0]  fail_code;
        logic [7:0]  scsi_status;
        logic [31:0] data_length;
        logic [31:0] xfer_bytes;
        logic [31:0] sense_written;
    } done_t;

    typedef struct packed {
        logic [7:0]  qid;
        logic [63:0] id;
        logic [7:0]  status;
        logic [7:0]  response;
        logic [31:0] sense_len;
        logic [31:0] residual;
        logic        out_partial;
    } resp_t;

    typedef struct packed {
        eng_state_t  st;
        req_t        req;
        exec_t       ex;
        resp_t       rsp;
        logic [7:0]  ctrl;
        logic [31:0] sense_size;
        logic [31:0] cdb_size;
        logic [7:0]  max_target;
        logic [31:0] done_cnt;
        logic [31:0] rdata;
    } eng_t;

endpackage : scsi_req_pkg

`default_nettype wire

// >>> rtl/scsi_request_queue_engine.sv
// Request queue engine of a virtual SCSI host adapter
`timescale 1ns/1ps
`default_nettype none
`include "scsi_req_cfg.svh"

module scsi_request_queue_engine (
    input  wire logic                 clk_i,
    input  wire logic                 reset_i,
    input  wire logic                 req_valid_i,
    input  wire scsi_req_pkg::req_t   req_i,
    output logic                      req_ready_o,
    output logic                      exec_valid_o,
    output scsi_req_pkg::exec_t       exec_o,
    input  wire logic                 exec_ready_i,
    output logic                      exec_cancel_o,
    input  wire logic                 done_valid_i,
    input  wire scsi_req_pkg::done_t  done_i,
    input  wire logic                 abort_i,
    input  wire logic [63:0]          abort_id_i,
    input  wire logic                 bus_reset_i,
    input  wire logic                 drain_i,
    output logic                      drain_done_o,
    output logic                      resp_valid_o,
    output scsi_req_pkg::resp_t       resp_o,
    input  wire logic                 resp_ready_i,
    input  wire logic [7:0]           addr_i,
    input  wire logic [31:0]          wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic [31:0]               rdata_o
);

    scsi_req_pkg::eng_t s;
    scsi_req_pkg::eng_t next_s;

    // 0: malformed, 1: report-luns unit, 2: normal target/unit
    function automatic logic [1:0] lun_kind(input logic [7:0][7:0] lun);
        logic zero_tail;
        zero_tail = (lun[4] == 8'h00) && (lun[5] == 8'h00) &&
                    (lun[6] == 8'h00) && (lun[7] == 8'h00);
        if (lun[0] == `LUN_WK0 && lun[1] == `LUN_WK1 &&
            lun[2] == 8'h00 && lun[3] == 8'h00 && zero_tail) begin
            lun_kind = 2'h1;
        end else if (lun[0] == `LUN_NORMAL0 && zero_tail) begin
            lun_kind = 2'h2;
        end else begin
            lun_kind = 2'h0;
        end
    endfunction : lun_kind

    function automatic scsi_req_pkg::task_attr_t attr_map(
        input logic [7:0] a, input logic all_simple);
        if (all_simple) begin
            attr_map = scsi_req_pkg::ATTR_SIMPLE_E;
        end else begin
            case (a)
                `ATTR_ORDERED: attr_map = scsi_req_pkg::ATTR_ORDERED_E;
                `ATTR_HEAD:    attr_map = scsi_req_pkg::ATTR_HEAD_E;
                `ATTR_ACA:     attr_map = scsi_req_pkg::ATTR_ACA_E;
                default:       attr_map = scsi_req_pkg::ATTR_SIMPLE_E;
            endcase
        end
    endfunction : attr_map

    logic        feat_inout;
    logic        feat_pi;
    logic [1:0]  kind;
    logic [31:0] rd_hdr;
    logic [31:0] wr_hdr;
    logic [32:0] io_total;
    logic        cancel;
    logic [7:0]  cancel_code;

    assign feat_inout = s.ctrl[`FEAT_INOUT_BIT];
    assign feat_pi    = s.ctrl[`FEAT_PI_BIT];
    assign kind       = lun_kind(s.req.lun);
    // Descriptor sits right after the fixed header; protection fields follow
    assign rd_hdr = `HDR_FIXED_BYTES + s.cdb_size +
                    (feat_pi ? (`PI_HDR_BYTES + s.req.prot_out_count)
                             : 32'h0000_0000);
    // Incoming protection area comes before incoming data
    assign wr_hdr = `STS_FIXED_BYTES + s.sense_size +
                    (feat_pi ? s.req.prot_in_count : 32'h0000_0000);
    assign io_total = {1'b0, s.ex.dataout_len} + {1'b0, s.ex.datain_len};

    // Drain outranks reset, reset outranks a matching abort
    always_comb begin
        cancel      = 1'b0;
        cancel_code = `RESP_OK;
        if (drain_i) begin
            cancel      = 1'b1;
            cancel_code = `RESP_FAILURE;
        end else if (bus_reset_i) begin
            cancel      = 1'b1;
            cancel_code = `RESP_RESET;
        end else if (abort_i && abort_id_i == s.req.id) begin
            cancel      = 1'b1;
            cancel_code = `RESP_ABORTED;
        end
    end

    always_comb begin
        next_s = s;
        case (s.st)
            scsi_req_pkg::ST_IDLE: begin
                // Readable and writable lengths arrive already split
                if (req_valid_i && !drain_i) begin
                    next_s.req = req_i;
                    next_s.st  = scsi_req_pkg::ST_DECODE;
                end
            end
            scsi_req_pkg::ST_DECODE: begin
                next_s.ex.qid         = s.req.qid;
                next_s.ex.id          = s.req.id;
                next_s.ex.report_luns = (kind == 2'h1);
                next_s.ex.target      = s.req.lun[1];
                next_s.ex.unit        = {6'(s.req.lun[2] & `LUN_UNIT_MSK),
                                         s.req.lun[3]};
                next_s.ex.attr        = attr_map(s.req.task_attr,
                                            s.ctrl[`CTRL_SIMPLE_BIT]);
                next_s.ex.crn         = s.req.crn;
                next_s.ex.cdb_len     = s.cdb_size;
                next_s.ex.dataout_off = rd_hdr;
                next_s.ex.dataout_len = (s.req.rd_len >= rd_hdr) ?
                    s.req.rd_len - rd_hdr : 32'h0000_0000;
                next_s.ex.prot_in_off = `STS_FIXED_BYTES + s.sense_size;
                next_s.ex.datain_off  = wr_hdr;
                next_s.ex.datain_len  = (s.req.wr_len >= wr_hdr) ?
                    s.req.wr_len - wr_hdr : 32'h0000_0000;
                next_s.rsp.qid         = s.req.qid;
                next_s.rsp.id          = s.req.id;
                next_s.rsp.status      = 8'h00;
                next_s.rsp.sense_len   = 32'h0000_0000;
                next_s.rsp.residual    = 32'h0000_0000;
                next_s.rsp.out_partial = 1'b0;
                next_s.rsp.response    = `RESP_OK;
                if (drain_i) begin
                    next_s.rsp.response = `RESP_FAILURE;
                    next_s.st = scsi_req_pkg::ST_RESP;
                end else if (kind == 2'h0 || (kind == 2'h2 &&
                             s.req.lun[1] > s.max_target)) begin
                    // Never handed to the target
                    next_s.rsp.response = `RESP_BAD_TARGET;
                    next_s.st = scsi_req_pkg::ST_RESP;
                end else if (s.req.rd_len < rd_hdr || s.req.wr_len < wr_hdr ||
                             (!feat_inout && s.req.rd_len != rd_hdr &&
                              s.req.wr_len != wr_hdr)) begin
                    next_s.rsp.response = `RESP_FAILURE;
                    next_s.st = scsi_req_pkg::ST_RESP;
                end else begin
                    next_s.st = scsi_req_pkg::ST_EXEC;
                end
            end
            scsi_req_pkg::ST_EXEC: begin
                if (cancel) begin
                    next_s.rsp.response = cancel_code;
                    next_s.st = scsi_req_pkg::ST_RESP;
                end else if (exec_ready_i) begin
                    next_s.st = scsi_req_pkg::ST_WAIT;
                end
            end
            scsi_req_pkg::ST_WAIT: begin
                if (cancel) begin
                    next_s.rsp.response = cancel_code;
                    next_s.st = scsi_req_pkg::ST_RESP;
                end else if (done_valid_i) begin
                    next_s.st = scsi_req_pkg::ST_RESP;
                    next_s.rsp.status = done_i.scsi_status;
                    next_s.rsp.sense_len =
                        (done_i.sense_written > s.sense_size) ?
                        s.sense_size : done_i.sense_written;
                    // Moved bytes count both directions; clamp keeps it sane
                    next_s.rsp.residual =
                        (done_i.data_length > done_i.xfer_bytes) ?
                        done_i.data_length - done_i.xfer_bytes :
                        32'h0000_0000;
                    next_s.rsp.out_partial =
                        (next_s.rsp.residual > s.ex.datain_len);
                    if ({1'b0, done_i.data_length} > io_total) begin
                        next_s.rsp.response = `RESP_OVERRUN;
                    end else begin
                        // Target-side verdicts pass through unchanged
                        next_s.rsp.response = done_i.fail_code;
                    end
                end
            end
            scsi_req_pkg::ST_RESP: begin
                if (resp_ready_i) begin
                    next_s.st       = scsi_req_pkg::ST_IDLE;
                    next_s.done_cnt = s.done_cnt + 32'h0000_0001;
                end
            end
            default: next_s.st = scsi_req_pkg::ST_IDLE;
        endcase

        // Sizes written mid-request apply to the next decode; sense_size also clamps the pending sense length
        if (wr_i) begin
            case (addr_i)
                `REG_CTRL:       next_s.ctrl       = wdata_i[7:0];
                `REG_SENSE_SIZE: next_s.sense_size = wdata_i;
                `REG_CDB_SIZE:   next_s.cdb_size   = wdata_i;
                `REG_MAX_TARGET: next_s.max_target = wdata_i[7:0];
                default: ;
            endcase
        end
        next_s.rdata = 32'h0000_0000;
        if (rd_i) begin
            case (addr_i)
                `REG_CTRL:       next_s.rdata = {24'h00_0000, s.ctrl};
                `REG_SENSE_SIZE: next_s.rdata = s.sense_size;
                `REG_CDB_SIZE:   next_s.rdata = s.cdb_size;
                `REG_MAX_TARGET: next_s.rdata = {24'h00_0000, s.max_target};
                `REG_STATUS:     next_s.rdata = {16'h0000, s.rsp.response,
                                                 s.st == scsi_req_pkg::ST_IDLE,
                                                 4'h0, s.st};
                `REG_DONE_COUNT: next_s.rdata = s.done_cnt;
                default:         next_s.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s            <= '0;
            s.st         <= scsi_req_pkg::ST_IDLE;
            s.ctrl       <= `CTRL_RST;
            s.sense_size <= `SENSE_SIZE_RST;
            s.cdb_size   <= `CDB_SIZE_RST;
            s.max_target <= `MAX_TARGET_RST;
        end else begin
            s <= next_s;
        end
    end

    assign req_ready_o   = (s.st == scsi_req_pkg::ST_IDLE) && !drain_i;
    assign exec_valid_o  = (s.st == scsi_req_pkg::ST_EXEC);
    assign exec_o        = s.ex;
    assign exec_cancel_o = (s.st == scsi_req_pkg::ST_WAIT) && cancel;
    assign drain_done_o  = drain_i && (s.st == scsi_req_pkg::ST_IDLE);
    assign resp_valid_o  = (s.st == scsi_req_pkg::ST_RESP);
    assign resp_o        = s.rsp;
    assign rdata_o       = s.rdata;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    AST_QUEUE_RETURN: assert property (
        (s.st == scsi_req_pkg::ST_DECODE) |=>
            (s.rsp.qid == $past(s.req.qid)) throughout
            (s.st != scsi_req_pkg::ST_IDLE))
        else $error("completion queue differs from submission queue");

    AST_REPORT_LUNS: assert property (
        (s.st == scsi_req_pkg::ST_DECODE && s.req.lun[0] == `LUN_WK0 &&
         s.req.lun[1] == `LUN_WK1 && s.req.lun[7:2] == '0) |=>
            s.ex.report_luns && s.rsp.response != `RESP_BAD_TARGET)
        else $error("report-luns address not recognised");

    AST_BAD_TARGET: assert property (
        (s.st == scsi_req_pkg::ST_DECODE && !drain_i &&
         s.req.lun[0] == `LUN_NORMAL0 && s.req.lun[7:4] == '0 &&
         s.req.lun[1] > s.max_target) |=>
            resp_valid_o && resp_o.response == `RESP_BAD_TARGET ##1
            !exec_valid_o)
        else $error("missing target not answered as bad target");

    AST_ATTR_SIMPLE: assert property (
        exec_valid_o && s.ctrl[`CTRL_SIMPLE_BIT] && $stable(s.ctrl) |->
            exec_o.attr == scsi_req_pkg::ATTR_SIMPLE_E)
        else $error("attribute not mapped to simple");

    AST_CDB_PLACE: assert property (
        (s.st == scsi_req_pkg::ST_DECODE && !feat_pi && !wr_i) |=>
            exec_o.dataout_off == `HDR_FIXED_BYTES + $past(s.cdb_size))
        else $error("outgoing data offset wrong");

    AST_SENSE_LEN: assert property (
        (s.st == scsi_req_pkg::ST_WAIT && done_valid_i && !cancel &&
         done_i.sense_written <= s.sense_size) |=>
            resp_o.sense_len == $past(done_i.sense_written))
        else $error("sense length not the bytes written");

    AST_RESIDUAL: assert property (
        (s.st == scsi_req_pkg::ST_WAIT && done_valid_i && !cancel &&
         done_i.data_length >= done_i.xfer_bytes) |=>
            resp_o.residual ==
            $past(done_i.data_length) - $past(done_i.xfer_bytes))
        else $error("residual miscomputed");

    AST_OVERRUN: assert property (
        (s.st == scsi_req_pkg::ST_WAIT && done_valid_i && !cancel &&
         {1'b0, done_i.data_length} > io_total) |=>
            resp_valid_o && resp_o.response == `RESP_OVERRUN)
        else $error("overrun not reported");

    AST_BIDI_FAIL: assert property (
        (s.st == scsi_req_pkg::ST_DECODE && !feat_inout && !drain_i &&
         (kind == 2'h1 || (kind == 2'h2 && s.req.lun[1] <= s.max_target)) &&
         s.req.rd_len > rd_hdr && s.req.wr_len > wr_hdr) |=>
            resp_valid_o && resp_o.response == `RESP_FAILURE)
        else $error("unnegotiated bidirectional request not failed");

    AST_RESET_CANCEL: assert property (
        (s.st == scsi_req_pkg::ST_WAIT && bus_reset_i && !drain_i) |=>
            resp_valid_o && resp_o.response == `RESP_RESET)
        else $error("reset cancellation code wrong");

    AST_DRAIN: assert property (
        (s.st == scsi_req_pkg::ST_WAIT && drain_i) |=>
            resp_o.response == `RESP_FAILURE && !req_ready_o)
        else $error("outstanding command not failed on drain");

    AST_DEFAULTS: assert property (
        $past(reset_i) && !reset_i |->
            s.sense_size == `SENSE_SIZE_RST && s.cdb_size == `CDB_SIZE_RST)
        else $error("configuration defaults wrong after reset");

    COV_NORMAL: cover property (
        exec_valid_o && exec_ready_i ##[1:20] resp_valid_o &&
        resp_o.response == `RESP_OK);
    COV_ABORT: cover property (
        s.st == scsi_req_pkg::ST_WAIT && abort_i ##1
        resp_o.response == `RESP_ABORTED);
    COV_OVERRUN: cover property (resp_valid_o &&
        resp_o.response == `RESP_OVERRUN);
    COV_BADTGT: cover property (resp_valid_o &&
        resp_o.response == `RESP_BAD_TARGET);

endmodule : scsi_request_queue_engine

`default_nettype wire

// >>> dv/scsi_backend_model.sv
// Backend model that executes decoded commands for the queue engine
`timescale 1ns/1ps
`default_nettype none
module scsi_backend_model (
    input  wire logic                clk_i,
    input  wire logic                reset_i,
    input  wire logic                exec_valid_i,
    input  wire logic                exec_cancel_i,
    input  wire scsi_req_pkg::done_t plan_i,
    input  wire logic [7:0]          delay_i,
    output logic                     exec_ready_o,
    output logic                     done_valid_o,
    output scsi_req_pkg::done_t      done_o
);
    logic       busy;
    logic [7:0] cnt;
    // Outside the pulse the result lines carry junk, never the last value
    assign done_o = done_valid_o ? plan_i : ~plan_i;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            exec_ready_o <= 1'b0;
            done_valid_o <= 1'b0;
            busy         <= 1'b0;
            cnt          <= 8'h00;
        end else begin
            done_valid_o <= 1'b0;
            if (exec_ready_o) begin
                exec_ready_o <= 1'b0;
                busy         <= exec_valid_i;
                cnt          <= delay_i;
            end else if (exec_valid_i && !busy) begin
                exec_ready_o <= 1'b1;
            end else if (busy && exec_cancel_i) begin
                busy <= 1'b0; // Cancelled work gives no result
            end else if (busy && cnt == 8'h00) begin
                busy         <= 1'b0;
                done_valid_o <= 1'b1;
            end else if (busy) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule : scsi_backend_model
`default_nettype wire

// >>> dv/scsi_request_queue_engine_test.sv
// Self-checking bench for the SCSI request queue engine
`timescale 1ns/1ps
`default_nettype none
`include "scsi_req_cfg.svh"
module scsi_request_queue_engine_test;
    typedef struct packed {
        logic [7:0]          ctrl;
        logic [63:0]         lun;
        logic [7:0]          rd, wr, pi;
        scsi_req_pkg::done_t plan;
        logic [7:0]          resp, resid;
        logic                part;
    } row_t;
    localparam logic [63:0] LN = 64'h0000_0000_0541_0101;
    localparam logic [63:0] RL = 64'h0000_0000_0000_01C1;
    logic clk_i, reset_i, req_valid_i, req_ready_o, exec_valid_o, exec_ready;
    logic exec_cancel_o, done_valid, abort_i, bus_reset_i, drain_i;
    logic drain_done_o, resp_valid_o, resp_ready_i, wr_i, rd_i;
    logic [63:0] abort_id_i;
    logic [31:0] wdata_i, rdata_o;
    logic [7:0]  addr_i, delay;
    scsi_req_pkg::req_t  req_i, r;
    scsi_req_pkg::exec_t exec_o, last_ex;
    scsi_req_pkg::done_t done, plan;
    scsi_req_pkg::resp_t resp_o, q;
    row_t rows[$];
    int n_mismatch, num_checks, cyc;
    logic ex;
    scsi_request_queue_engine i_dut (.clk_i(clk_i), .reset_i(reset_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
        .exec_valid_o(exec_valid_o), .exec_o(exec_o),
        .exec_ready_i(exec_ready), .exec_cancel_o(exec_cancel_o),
        .done_valid_i(done_valid), .done_i(done), .abort_i(abort_i),
        .abort_id_i(abort_id_i), .bus_reset_i(bus_reset_i),
        .drain_i(drain_i), .drain_done_o(drain_done_o),
        .resp_valid_o(resp_valid_o), .resp_o(resp_o),
        .resp_ready_i(resp_ready_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
    scsi_backend_model i_backend (.clk_i(clk_i), .reset_i(reset_i),
        .exec_valid_i(exec_valid_o), .exec_cancel_i(exec_cancel_o),
        .plan_i(plan), .delay_i(delay), .exec_ready_o(exec_ready),
        .done_valid_o(done_valid), .done_o(done));
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (exec_valid_o && exec_ready) last_ex <= exec_o;
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string n, input logic [63:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %0h seen %0h", n, e, g);
        end
    endtask : chk
    task automatic add(input logic [7:0] c, input logic [63:0] l,
            input logic [7:0] rd, wr, pi, f, s, d, x, w, rs, rr,
            input logic p);
        rows.push_back('{c, l, rd, wr, pi,
            '{f, s, 32'(d), 32'(x), 32'(w)}, rs, rr, p});
    endtask : add
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        chk("rdata", e, rdata_o);
    endtask : rd_chk
    task automatic xfer(input logic [63:0] l, input logic [7:0] id);
        r = '0; // Attribute, priority and crn stay zero
        r.lun    = l;
        r.id     = 64'(id);
        r.rd_len = 32'h33;
        r.wr_len = 32'h6C; // No incoming data, so never refused as bidirectional
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_i       <= r;
        @(posedge clk_i);
        req_valid_i <= 1'b0;
    endtask : xfer
    task automatic get_resp;
        int n;
        n = 0;
        @(negedge clk_i);
        while (resp_valid_o !== 1'b1 && n < 300) begin
            @(negedge clk_i);
            n++;
        end
        chk("resp_valid", 64'h1, 64'(resp_valid_o));
        q = resp_o; // Used length is never consulted
        @(posedge clk_i);
        resp_ready_i <= 1'b1;
        @(posedge clk_i);
        resp_ready_i <= 1'b0;
    endtask : get_resp
    task automatic cancel(input int k, input logic [7:0] code);
        delay <= 8'h28;
        xfer(LN, 8'h77);
        repeat (6) @(posedge clk_i);
        abort_i     <= (k == 0);
        abort_id_i  <= 64'h77;
        bus_reset_i <= (k == 1);
        drain_i     <= (k == 2);
        get_resp();
        chk("cancel", 64'(code), 64'(q.response));
        @(negedge clk_i);
        chk("drain_done", 64'(k == 2), 64'(drain_done_o));
        @(posedge clk_i);
        abort_i     <= 1'b0;
        bus_reset_i <= 1'b0;
        drain_i     <= 1'b0;
        $display("cancel test %0d done", k);
    endtask : cancel
    initial begin
        {reset_i, req_valid_i, abort_i, bus_reset_i, drain_i} = 5'h10;
        {resp_ready_i, wr_i, rd_i, addr_i, wdata_i, abort_id_i} = '0;
        {req_i, plan, delay, n_mismatch, num_checks, cyc} = '0;
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        rd_chk(`REG_SENSE_SIZE, 32'h60);
        rd_chk(`REG_CDB_SIZE, 32'h20);
        add(8'h00, LN, 8'h33, 8'hAC, 8'h00, 8'h00, 8'h02, 8'h40, 8'h3C,
            8'h12, 8'h00, 8'h04, 1'b0);
        add(8'h00, RL, 8'h33, 8'hAC, 8'h00, 8'h00, 8'h00, 8'h40, 8'h40,
            8'h00, 8'h00, 8'h00, 1'b0);
        add(8'h00, LN, 8'h33, 8'hAC, 8'h00, 8'h00, 8'h00, 8'h64, 8'h3C,
            8'h00, 8'h01, 8'h28, 1'b0);
        for (int k = 5; k < 9; k++) add(8'h00, LN, 8'h33, 8'hAC, 8'h00,
            8'(k), 8'h00, 8'h00, 8'h00, 8'h00, 8'(k), 8'h00, 1'b0);
        add(8'h00, LN, 8'h43, 8'hAC, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h09, 8'h00, 1'b0);
        add(8'h01, LN, 8'h43, 8'hAC, 8'h00, 8'h00, 8'h00, 8'h50, 8'h46,
            8'h00, 8'h00, 8'h0A, 1'b0);
        add(8'h10, LN, 8'h53, 8'h6C, 8'h00, 8'h00, 8'h00, 8'h20, 8'h0A,
            8'h00, 8'h00, 8'h16, 1'b1);
        add(8'h00, 64'h0040_0102, 8'h33, 8'hAC, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 1'b0);
        add(8'h09, LN, 8'h53, 8'hAC, 8'h08, 8'h00, 8'h00, 8'h46, 8'h0A,
            8'h00, 8'h00, 8'h3C, 1'b1);
        foreach (rows[i]) begin
            wr_reg(`REG_CTRL, {24'h0, rows[i].ctrl});
            plan  <= rows[i].plan;
            delay <= 8'(i);
            r = '0;
            r.qid = 8'(i);
            r.lun = rows[i].lun;
            r.id = 64'(i) + 64'h100;
            r.task_attr = 8'(i % 4);
            r.crn = 8'(255 - i);
            r.rd_len = 32'(rows[i].rd);
            r.wr_len = 32'(rows[i].wr);
            r.prot_out_count = 32'(rows[i].pi);
            r.prot_in_count = 32'(rows[i].pi);
            @(posedge clk_i);
            req_valid_i <= 1'b1;
            req_i       <= r;
            @(posedge clk_i);
            req_valid_i <= 1'b0;
            get_resp();
            ex = rows[i].resp != 8'h03 && rows[i].resp != 8'h09;
            chk("qid", 64'(i), 64'(q.qid));
            chk("id", r.id, q.id);
            chk("response", 64'(rows[i].resp),
                64'(q.response));
            chk("status", ex ? 64'(rows[i].plan.scsi_status) : 0,
                64'(q.status));
            chk("sense_len", ex ? 64'(rows[i].plan.sense_written) : 0,
                64'(q.sense_len));
            chk("residual", 64'(rows[i].resid),
                64'(q.residual));
            chk("out_partial", 64'(rows[i].part),
                64'(q.out_partial));
            if (ex) begin
                chk("attr", rows[i].ctrl[`CTRL_SIMPLE_BIT] ? 64'h0 :
                    64'(i % 4), 64'(last_ex.attr));
                chk("crn", 64'(r.crn), 64'(last_ex.crn));
                chk("report", 64'(r.lun == RL),
                    64'(last_ex.report_luns));
                chk("target", 64'(rows[i].lun[15:8]),
                    64'(last_ex.target));
                chk("unit", {50'h0, rows[i].lun[21:16], rows[i].lun[31:24]},
                    64'(last_ex.unit));
            end
            $display("row %0d done", i);
        end
        plan <= '0;
        wr_reg(`REG_CTRL, 32'h0);
        wr_reg(`REG_MAX_TARGET, 32'h0);
        xfer(LN, 8'h01);
        get_resp();
        chk("bad target", 64'h3, 64'(q.response));
        wr_reg(`REG_MAX_TARGET, 32'hFF);
        wr_reg(`REG_CDB_SIZE, 32'h10);
        xfer(LN, 8'h02);
        get_resp();
        chk("cdb_len", 64'h10, 64'(last_ex.cdb_len));
        chk("dataout", 64'h10, 64'(last_ex.dataout_len));
        $display("config test done");
        @(posedge clk_i);
        reset_i <= 1'b1;
        @(posedge clk_i);
        reset_i <= 1'b0;
        rd_chk(`REG_CDB_SIZE, 32'h20);
        rd_chk(8'h40, 32'h0);
        cancel(0, 8'h02);
        cancel(1, 8'h04);
        cancel(2, 8'h09);
        conclude();
    end
endmodule : scsi_request_queue_engine_test
`default_nettype wire
